//--- rtl/cssc_clock_source_startup_control.v
`timescale 1ns/10ps
`include "cssc_defs.vh"
module cssc_clock_source_startup_control #(
   parameter [13:0] TOUT_LONG_CYCLES = `CSSC_TOUT_LONG,
   parameter [15:0] SU_16K_CYCLES    = `CSSC_SU_16K,
   parameter [15:0] SU_32K_CYCLES    = `CSSC_SU_32K
) (
   // Clock and reset
   input  wire        clock_in,
   input  wire        rst_n_in,
   // Fuses, raw stored values
   input  wire [3:0]  clock_source_select_in,
   input  wire [1:0]  startup_time_select_in,
   input  wire        divide_by_eight_fuse_in,
   input  wire        fuse_default_in,
   // Reset sources and sleep
   input  wire        ext_reset_hold_in,
   input  wire        sleep_wake_in,
   input  wire        sleep_active_in,
   input  wire [2:0]  sleep_mode_in,
   // Oscillator clocks, sampled as pins
   input  wire        wdt_osc_in,
   input  wire        src_osc_in,
   input  wire        async_xtal_in,
   // Status and control
   output reg  [2:0]  clock_source_out,
   output reg  [2:0]  osc_enable_out,
   output reg         internal_reset_out,
   output reg         sys_clk_en_out,
   output reg         cpu_clk_en_out,
   output reg         io_clk_en_out,
   output reg         flash_clk_en_out,
   output reg         asy_clk_en_out,
   output reg         adc_clk_en_out,
   output reg         async_wake_en_out,
   output reg         addr_match_en_out,
   output reg         asy_tick_out
);
   localparam [2:0] ST_TIMEOUT = 3'h0;
   localparam [2:0] ST_STARTUP = 3'h1;
   localparam [2:0] ST_RUN     = 3'h2;
   localparam [2:0] ST_SLEEP   = 3'h3;
   localparam [2:0] ST_HALT    = 3'h4;

   localparam [2:0] SM_IDLE    = 3'h0;
   localparam [2:0] SM_ADCNR   = 3'h1;
   localparam [2:0] SM_PDOWN   = 3'h2;
   localparam [2:0] SM_PSAVE   = 3'h3;
   localparam [2:0] SM_STBY    = 3'h6;
   localparam [2:0] SM_XSTBY   = 3'h7;

   reg  [2:0]  state_q;
   reg  [2:0]  state_d;
   reg  [13:0] tout_cnt_q;
   reg  [15:0] su_cnt_q;
   reg  [2:0]  div_q;
   reg  [2:0]  wdt_sync_q;
   reg  [2:0]  osc_sync_q;
   reg  [2:0]  asy_sync_q;
   reg         wdt_lvl_q;
   reg         osc_lvl_q;
   reg         asy_lvl_q;
   reg  [3:0]  clock_source_select_q;
   reg  [1:0]  sut_q;
   reg         div8_q;

   wire        wdt_edge;
   wire        osc_edge;
   wire        asy_edge;
   wire [2:0]  src_sel;
   wire [13:0] tout_len;
   wire [15:0] su_len;

   // Source decode, inverted polarity kept: raw 1 = unprogrammed.
   function [2:0] decode_src;
      input [3:0] cks;
      begin
         if (cks >= `CSSC_CLOCK_SOURCE_SELECT_LP_LO)
            decode_src = `CSSC_SRC_LP_XTAL;
         else if (cks >= `CSSC_CLOCK_SOURCE_SELECT_FS_LO)
            decode_src = `CSSC_SRC_FS_XTAL;
         else if (cks >= `CSSC_CLOCK_SOURCE_SELECT_LF_LO)
            decode_src = `CSSC_SRC_LF_XTAL;
         else if (cks == `CSSC_CLOCK_SOURCE_SELECT_RC_128K)
            decode_src = `CSSC_SRC_RC_128K;
         else if (cks == `CSSC_CLOCK_SOURCE_SELECT_RC_CAL)
            decode_src = `CSSC_SRC_RC_CAL;
         else if (cks == `CSSC_CLOCK_SOURCE_SELECT_EXT)
            decode_src = `CSSC_SRC_EXT;
         else
            decode_src = `CSSC_SRC_NONE;
      end
   endfunction

   // Time-out length from start-up select.
   function [13:0] decode_tout;
      input [1:0] startup_time_select;
      begin
         case (startup_time_select)
            `CSSC_SUT_NONE:  decode_tout = `CSSC_TOUT_NONE;
            `CSSC_SUT_SHORT: decode_tout = `CSSC_TOUT_SHORT;
            default: decode_tout = TOUT_LONG_CYCLES;
         endcase
      end
   endfunction

   // Start-up length from source and crystal selection bits.
   function [15:0] decode_su;
      input [2:0] src;
      input       ck0;
      input [1:0] startup_time_select;
      begin
         case (src)
            `CSSC_SRC_EXT:     decode_su = `CSSC_SU_EXT;
            `CSSC_SRC_LF_XTAL: decode_su = SU_32K_CYCLES;
            `CSSC_SRC_LP_XTAL, `CSSC_SRC_FS_XTAL: begin
               if (!ck0 && startup_time_select[`CSSC_SUT_MSB] == 1'b0)
                  decode_su = `CSSC_SU_258;
               else if (!ck0 || startup_time_select == `CSSC_SUT_NONE)
                  decode_su = `CSSC_SU_1K;
               else
                  decode_su = SU_16K_CYCLES;
            end
            default:           decode_su = `CSSC_SU_EXT;
         endcase
      end
   endfunction

   // A pin level counts once the second and third stages agree.
   function sync_agree;
      input [2:0] sync;
      begin
         sync_agree = (sync[1] == sync[2]);
      end
   endfunction

   // Rising edge of the agreed pin level against the last accepted level.
   function sync_rise;
      input [2:0] sync;
      input       lvl;
      begin
         sync_rise = sync_agree(sync) && sync[2] && !lvl;
      end
   endfunction

   // The I/O domain keeps running only in idle sleep.
   function io_runs_in_sleep;
      input [2:0] mode;
      begin
         case (mode)
            SM_IDLE:
               io_runs_in_sleep = 1'b1;
            SM_ADCNR, SM_PDOWN, SM_PSAVE, SM_STBY, SM_XSTBY:
               io_runs_in_sleep = 1'b0;
            default:
               io_runs_in_sleep = 1'b0;
         endcase
      end
   endfunction

   // The converter domain runs in idle and in noise reduction sleep.
   function adc_runs_in_sleep;
      input [2:0] mode;
      begin
         case (mode)
            SM_IDLE, SM_ADCNR:
               adc_runs_in_sleep = 1'b1;
            SM_PDOWN, SM_PSAVE, SM_STBY, SM_XSTBY:
               adc_runs_in_sleep = 1'b0;
            default:
               adc_runs_in_sleep = 1'b0;
         endcase
      end
   endfunction

   // The asynchronous timer domain keeps the real-time counter alive.
   function asy_runs_in_sleep;
      input [2:0] mode;
      begin
         case (mode)
            SM_IDLE, SM_ADCNR, SM_PSAVE, SM_XSTBY:
               asy_runs_in_sleep = 1'b1;
            SM_PDOWN, SM_STBY:
               asy_runs_in_sleep = 1'b0;
            default:
               asy_runs_in_sleep = 1'b0;
         endcase
      end
   endfunction

   assign src_sel  = decode_src(clock_source_select_q);
   assign tout_len = decode_tout(sut_q);
   assign su_len   = decode_su(src_sel, clock_source_select_q[`CSSC_CLOCK_SOURCE_SELECT_LSB], sut_q);
   assign wdt_edge = sync_rise(wdt_sync_q, wdt_lvl_q);
   assign osc_edge = sync_rise(osc_sync_q, osc_lvl_q);
   assign asy_edge = sync_rise(asy_sync_q, asy_lvl_q);

   // Oscillator pins pass three flip-flops.
   always @(posedge clock_in) begin
      wdt_sync_q <= {wdt_sync_q[1:0], wdt_osc_in};
      osc_sync_q <= {osc_sync_q[1:0], src_osc_in};
      asy_sync_q <= {asy_sync_q[1:0], async_xtal_in};
   end

   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         wdt_lvl_q <= 1'b0;
         osc_lvl_q <= 1'b0;
         asy_lvl_q <= 1'b0;
      end else begin
         if (sync_agree(wdt_sync_q))
            wdt_lvl_q <= wdt_sync_q[2];
         if (sync_agree(osc_sync_q))
            osc_lvl_q <= osc_sync_q[2];
         if (sync_agree(asy_sync_q))
            asy_lvl_q <= asy_sync_q[2];
      end
   end

   // Fuses captured in the time-out state; default selection loaded in reset and when requested.
   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         clock_source_select_q <= `CSSC_DEF_CLOCK_SOURCE_SELECT;
         sut_q   <= `CSSC_DEF_SUT;
         div8_q  <= `CSSC_DEF_DIV8;
      end else if (state_q == ST_TIMEOUT && fuse_default_in) begin
         clock_source_select_q <= `CSSC_DEF_CLOCK_SOURCE_SELECT;
         sut_q   <= `CSSC_DEF_SUT;
         div8_q  <= `CSSC_DEF_DIV8;
      end else if (state_q == ST_TIMEOUT) begin
         clock_source_select_q <= clock_source_select_in;
         sut_q   <= startup_time_select_in;
         div8_q  <= divide_by_eight_fuse_in;
      end
   end

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_TIMEOUT: begin
            if (src_sel == `CSSC_SRC_NONE)
               state_d = ST_HALT;
            else if (!ext_reset_hold_in && tout_cnt_q >= tout_len)
               state_d = ST_STARTUP;
         end
         ST_STARTUP: begin
            if (su_cnt_q >= su_len)
               state_d = ST_RUN;
         end
         ST_RUN: begin
            if (sleep_active_in)
               state_d = ST_SLEEP;
         end
         ST_SLEEP: begin
            if (sleep_wake_in)
               state_d = ST_STARTUP;
         end
         ST_HALT:    state_d = ST_HALT;
         default:    state_d = ST_TIMEOUT;
      endcase
   end

   always @(posedge clock_in) begin
      if (!rst_n_in || ext_reset_hold_in) begin
         state_q    <= ST_TIMEOUT;
         tout_cnt_q <= `CSSC_TOUT_NONE;
         su_cnt_q   <= `CSSC_SU_NONE;
      end else begin
         state_q <= state_d;
         if (state_q == ST_TIMEOUT && wdt_edge && tout_cnt_q < tout_len)
            tout_cnt_q <= tout_cnt_q + 14'h0001;
         if (state_q != ST_STARTUP)
            su_cnt_q <= `CSSC_SU_NONE;
         else if (osc_edge)
            su_cnt_q <= su_cnt_q + 16'h0001;
      end
   end

   // System clock prescaler: one enable in eight when the fuse is programmed.
   always @(posedge clock_in) begin
      if (!rst_n_in)
         div_q <= `CSSC_DIV8_FIRST;
      else
         div_q <= div_q + 3'h1;
   end

   always @(posedge clock_in) begin
      if (!rst_n_in) begin
         clock_source_out   <= `CSSC_SRC_NONE;
         osc_enable_out     <= 3'h0;
         internal_reset_out <= 1'b1;
         sys_clk_en_out     <= 1'b0;
         cpu_clk_en_out     <= 1'b0;
         io_clk_en_out      <= 1'b0;
         flash_clk_en_out   <= 1'b0;
         asy_clk_en_out     <= 1'b0;
         adc_clk_en_out     <= 1'b0;
         async_wake_en_out  <= 1'b0;
         addr_match_en_out  <= 1'b0;
         asy_tick_out       <= 1'b0;
      end else begin
         clock_source_out   <= src_sel;
         osc_enable_out     <= (state_q == ST_HALT) ? `CSSC_SRC_NONE : src_sel;
         internal_reset_out <= (state_q != ST_RUN) && (state_q != ST_SLEEP);
         sys_clk_en_out     <= (state_q == ST_RUN) && (div8_q || div_q == `CSSC_DIV8_LAST);
         cpu_clk_en_out     <= (state_q == ST_RUN);
         flash_clk_en_out   <= (state_q == ST_RUN);
         if (state_q == ST_SLEEP) begin
            io_clk_en_out  <= io_runs_in_sleep(sleep_mode_in);
            adc_clk_en_out <= adc_runs_in_sleep(sleep_mode_in);
            asy_clk_en_out <= asy_runs_in_sleep(sleep_mode_in);
         end else begin
            io_clk_en_out  <= (state_q == ST_RUN);
            adc_clk_en_out <= (state_q == ST_RUN);
            asy_clk_en_out <= (state_q == ST_RUN);
         end
         async_wake_en_out  <= (state_q == ST_SLEEP) && !io_runs_in_sleep(sleep_mode_in);
         addr_match_en_out  <= (state_q == ST_RUN) || (state_q == ST_SLEEP);
         asy_tick_out       <= asy_clk_en_out && asy_edge;
      end
   end

   // Glitch-free gate for the core domain only; the other domains have enable outputs and no gate.
   cssc_clock_gate u_cpu_gate (
      .clk_src_in    (clock_in),
      .enable_in     (state_q == ST_RUN),
      .clk_gated_out ()
   );

endmodule // cssc_clock_source_startup_control

//--- pkg/cssc_defs.vh
`ifndef CSSC_DEFS_VH
`define CSSC_DEFS_VH

// Clock source select codes, with fuse polarity inversion kept (raw stored values).
`define CSSC_SRC_EXT         3'h0
`define CSSC_SRC_RC_CAL      3'h1
`define CSSC_SRC_RC_128K     3'h2
`define CSSC_SRC_LF_XTAL     3'h3
`define CSSC_SRC_FS_XTAL     3'h4
`define CSSC_SRC_LP_XTAL     3'h5
`define CSSC_SRC_NONE        3'h6

`define CSSC_CLOCK_SOURCE_SELECT_EXT       4'h0
`define CSSC_CLOCK_SOURCE_SELECT_RSVD      4'h1
`define CSSC_CLOCK_SOURCE_SELECT_RC_CAL    4'h2
`define CSSC_CLOCK_SOURCE_SELECT_RC_128K   4'h3
`define CSSC_CLOCK_SOURCE_SELECT_LF_LO     4'h4
`define CSSC_CLOCK_SOURCE_SELECT_FS_LO     4'h6
`define CSSC_CLOCK_SOURCE_SELECT_LP_LO     4'h8
`define CSSC_CLOCK_SOURCE_SELECT_LSB       0

// Start-up time select field codes.
`define CSSC_SUT_NONE        2'h0
`define CSSC_SUT_SHORT       2'h1
`define CSSC_SUT_MSB         1

// Factory default fuse values.
`define CSSC_DEF_CLOCK_SOURCE_SELECT       4'h2
`define CSSC_DEF_SUT         2'h2
`define CSSC_DEF_DIV8        1'h0

// Time-out lengths in watchdog oscillator cycles.
`define CSSC_TOUT_NONE       14'h0000
`define CSSC_TOUT_SHORT      14'h0200
`define CSSC_TOUT_LONG       14'h2000

// Oscillator start-up counts in source clock cycles.
`define CSSC_SU_NONE         16'h0000
`define CSSC_SU_EXT          16'h0006
`define CSSC_SU_258          16'h0102
`define CSSC_SU_1K           16'h0400
`define CSSC_SU_16K          16'h4000
`define CSSC_SU_32K          16'h8000

`define CSSC_DIV8_FIRST      3'h0
`define CSSC_DIV8_LAST       3'h7

`endif

//--- rtl/cssc_clock_gate.v
`timescale 1ns/10ps
module cssc_clock_gate (
   // Clock and enable
   input  wire clk_src_in,
   input  wire enable_in,
   // Gated clock
   output wire clk_gated_out
);
   reg en_latch_q;

   // The enable is captured on the falling edge so it changes while the clock is low.
   always @(negedge clk_src_in) begin
      en_latch_q <= enable_in;
   end

   assign clk_gated_out = clk_src_in & en_latch_q;

endmodule // cssc_clock_gate

//--- test/cssc_osc_model.sv
`timescale 1ns/10ps
module cssc_osc_model #(
   parameter real WDT_HALF = 40.0,
   parameter real SRC_HALF = 30.0,
   parameter real ASY_HALF = 70.0
) (
   // Free-running oscillator pins
   output logic wdt_osc_out,
   output logic src_osc_out,
   output logic async_xtal_out
);
   initial wdt_osc_out = 1'b0;
   initial src_osc_out = 1'b1;
   initial async_xtal_out = 1'b0;
   always #(WDT_HALF) wdt_osc_out = ~wdt_osc_out;
   always #(SRC_HALF) src_osc_out = ~src_osc_out;
   always #(ASY_HALF) async_xtal_out = ~async_xtal_out;
endmodule // cssc_osc_model

//--- test/cssc_assertions.sv
`timescale 1ns/10ps
module cssc_checker (
   // Clock, reset and fuses
   input wire       clock_in,
   input wire       rst_n_in,
   input wire       divide_by_eight_fuse_in,
   input wire       fuse_default_in,
   // Status and enables
   input wire [2:0] clock_source_out,
   input wire [2:0] osc_enable_out,
   input wire       internal_reset_out,
   input wire       sys_clk_en_out,
   input wire       cpu_clk_en_out,
   input wire       flash_clk_en_out,
   input wire       async_wake_en_out,
   input wire       addr_match_en_out,
   input wire       asy_tick_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   a_rsvd_holds_rst: assert property (osc_enable_out == 3'h6 |-> internal_reset_out)
      else $error("reset released on halted source");
   a_osc_follows_src: assert property (!internal_reset_out |-> osc_enable_out == clock_source_out)
      else $error("oscillator enable differs from source");
   a_src_stable_run: assert property (
      !internal_reset_out && !$past(internal_reset_out) |-> $stable(clock_source_out))
      else $error("source changed while running");
   a_cpu_off_reset: assert property (internal_reset_out && $past(internal_reset_out) |-> !cpu_clk_en_out)
      else $error("core clock on during reset");
   a_flash_with_cpu: assert property (flash_clk_en_out == cpu_clk_en_out)
      else $error("flash clock apart from core clock");
   a_div8_spacing: assert property (
      sys_clk_en_out && (!divide_by_eight_fuse_in || fuse_default_in) |=> !sys_clk_en_out [*7])
      else $error("divided clock enable too frequent");
   a_addr_in_sleep: assert property (async_wake_en_out |-> addr_match_en_out)
      else $error("address match off in sleep");
   a_sleep_cpu_off: assert property (async_wake_en_out && $past(async_wake_en_out) |-> !cpu_clk_en_out)
      else $error("core clock on in sleep");
   a_tick_pulse: assert property (asy_tick_out |=> !asy_tick_out)
      else $error("timer tick longer than one cycle");
endmodule // cssc_checker

bind cssc_clock_source_startup_control cssc_checker u_chk (
   .clock_in, .rst_n_in, .divide_by_eight_fuse_in, .fuse_default_in, .clock_source_out,
   .osc_enable_out, .internal_reset_out, .sys_clk_en_out, .cpu_clk_en_out, .flash_clk_en_out,
   .async_wake_en_out, .addr_match_en_out, .asy_tick_out
);

//--- test/tb.sv
`timescale 1ns/10ps
module tb;
   localparam real WP = 8.26;
   localparam real SP = 6.34;
   logic       clock_in, rst_n_in, div8, fdef, hold, wake, slp;
   logic [3:0] cks;
   logic [1:0] startup_time_select;
   logic [2:0] mode;
   wire        wdt, src, axt, irst, sys_en, cpu_en, io_en, fl_en;
   wire        asy_en, adc_en, awk_en, am_en, tick;
   wire  [2:0] src_o, osc_o;
   integer     error_cnt = 0, num_checks = 0;
   cssc_osc_model #(.WDT_HALF(41.3), .SRC_HALF(31.7), .ASY_HALF(77.1)) u_osc (
      .wdt_osc_out(wdt), .src_osc_out(src), .async_xtal_out(axt));
   cssc_clock_source_startup_control #(
      .TOUT_LONG_CYCLES(14'h0010), .SU_16K_CYCLES(16'h0014), .SU_32K_CYCLES(16'h0018)
   ) u_dut (
      .clock_in, .rst_n_in, .clock_source_select_in(cks), .startup_time_select_in(startup_time_select),
      .divide_by_eight_fuse_in(div8), .fuse_default_in(fdef), .ext_reset_hold_in(hold),
      .sleep_wake_in(wake), .sleep_active_in(slp), .sleep_mode_in(mode), .wdt_osc_in(wdt),
      .src_osc_in(src), .async_xtal_in(axt), .clock_source_out(src_o), .osc_enable_out(osc_o),
      .internal_reset_out(irst), .sys_clk_en_out(sys_en), .cpu_clk_en_out(cpu_en),
      .io_clk_en_out(io_en), .flash_clk_en_out(fl_en), .asy_clk_en_out(asy_en),
      .adc_clk_en_out(adc_en), .async_wake_en_out(awk_en), .addr_match_en_out(am_en),
      .asy_tick_out(tick));
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task complete_run;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic restart(input logic [3:0] c, input logic [1:0] s, input logic d, input logic f);
      @(negedge clock_in);
      rst_n_in = 1'b0;
      cks = c;
      startup_time_select = s;
      div8 = d;
      fdef = f;
      hold = 1'b1;
      repeat (5) @(negedge clock_in);
      rst_n_in = 1'b1;
      repeat (3) @(negedge clock_in);
   endtask
   task automatic settle(input real e);
      integer n;
      repeat (17) @(negedge clock_in);
      check("held by source", irst, 1'b1);
      hold = 1'b0;
      n = 0;
      while (irst !== 1'b0 && n < 9000) begin
         @(negedge clock_in);
         n++;
      end
      check("release delay", n > e - 20 && n < e + 30, 1'b1);
   endtask
   task automatic rate(input logic [15:0] exp);
      integer c;
      c = 0;
      repeat (2) @(negedge clock_in);
      repeat (80) begin
         @(negedge clock_in);
         c += sys_en;
      end
      check("system rate", c, exp);
   endtask
   function automatic logic [35:0] row(input int k);
      case (k)
         0: row = {4'h0, 2'h0, 14'h0000, 16'h0006};
         1: row = {4'h0, 2'h1, 14'h0200, 16'h0006};
         2: row = {4'h0, 2'h2, 14'h0010, 16'h0006};
         3: row = {4'h6, 2'h0, 14'h0000, 16'h0102};
         4: row = {4'h7, 2'h3, 14'h0010, 16'h0014};
         5: row = {4'h7, 2'h0, 14'h0000, 16'h0400};
         6: row = {4'h4, 2'h0, 14'h0000, 16'h0018};
         default: row = {4'h2, 2'h0, 14'h0000, 16'h0006};
      endcase
   endfunction
   task automatic t_decode;
      logic [2:0] e;
      for (int i = 0; i < 16; i++) begin
         e = i >= 8 ? 3'h5 : i >= 6 ? 3'h4 : i >= 4 ? 3'h3 : i == 3 ? 3'h2 : i == 2 ? 3'h1 : i == 1 ? 3'h6 : 3'h0;
         restart(i, 2'h0, 1'b1, 1'b0);
         check("source", src_o, e);
         if (i == 1) begin
            hold = 1'b0;
            repeat (300) @(negedge clock_in);
            check("reserved reset", irst, 1'b1);
            check("reserved osc", osc_o, 3'h6);
         end
      end
   endtask
   task automatic t_default;
      restart(4'h0, 2'h0, 1'b1, 1'b1);
      check("default source", src_o, 3'h1);
      settle(16 * WP + 6 * SP);
      rate(16'h000a);
      restart(4'h0, 2'h0, 1'b0, 1'b0);
      settle(6 * SP);
      rate(16'h000a);
   endtask
   task automatic t_timing;
      logic [35:0] r;
      for (int k = 0; k < 8; k++) begin
         r = row(k);
         restart(r[35:32], r[31:30], 1'b1, 1'b0);
         settle(r[29:16] * WP + r[15:0] * SP);
         rate(16'h0050);
         check("core run", cpu_en, 1'b1);
      end
   endtask
   task automatic t_sleep;
      integer     n;
      logic [2:0] md;
      restart(4'h0, 2'h2, 1'b1, 1'b0);
      settle(16 * WP + 6 * SP);
      for (int m = 0; m < 6; m++) begin
         md = (m < 4) ? 3'(m) : 3'(m + 2);
         repeat (4) @(negedge clock_in);
         slp = 1'b1;
         mode = md;
         @(negedge clock_in);
         slp = 1'b0;
         repeat (4) @(negedge clock_in);
         check("core sleep", cpu_en, 1'b0);
         check("flash sleep", fl_en, 1'b0);
         check("io sleep", io_en, md == 3'h0);
         check("async wake", awk_en, md != 3'h0);
         check("addr match", am_en, 1'b1);
         check("adc sleep", adc_en, md <= 3'h1);
         check("timer clock sleep", asy_en, md <= 3'h1 || md == 3'h3 || md == 3'h7);
         n = 0;
         while ((md == 3'h3 || md == 3'h7) && tick !== 1'b1 && n < 40) begin
            @(negedge clock_in);
            n++;
         end
         if (md == 3'h3 || md == 3'h7) check("timer tick", tick, 1'b1);
         wake = 1'b1;
         @(negedge clock_in);
         wake = 1'b0;
         n = 0;
         while (cpu_en !== 1'b1 && n < 200) begin
            @(negedge clock_in);
            n++;
         end
         check("wake time", n < 80 && irst === 1'b0, 1'b1);
      end
   endtask
   initial begin
      #1_000_000;
      error_cnt++;
      complete_run;
   end
   initial begin
      {rst_n_in, div8, fdef, hold, wake, slp} = 6'h08;
      {cks, startup_time_select, mode} = 9'h000;
      t_decode;
      t_default;
      t_timing;
      t_sleep;
      complete_run;
   end
endmodule // tb
